// >>> design/bcc_pkg.sv
package bcc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] BCC_OFS_CTRL = 8'h00;
  localparam logic [7:0] BCC_OFS_STATUS = 8'h04;
  localparam logic [7:0] BCC_OFS_MASK = 8'h08;
  localparam logic [7:0] BCC_OFS_CWORD = 8'h0C;
  localparam logic [7:0] BCC_OFS_SADDR = 8'h10;
  localparam int BCC_CTRL_ENABLE = 0;
  localparam logic BCC_CTRL_ENABLE_RST = 1'b1;

  // ==========================================================================
  // Event bits of the status and mask registers
  localparam int BCC_EVT_W = 4;
  localparam int BCC_EVT_ADDR_FAULT = 0;
  localparam int BCC_EVT_DATA_FAULT = 1;
  localparam int BCC_EVT_DONE = 2;
  localparam int BCC_EVT_SHORT_CYCLE = 3;
  localparam logic [BCC_EVT_W-1:0] BCC_STATUS_RST = 4'h0;
  localparam logic [BCC_EVT_W-1:0] BCC_MASK_RST = 4'h0;

  // ==========================================================================
  // Captured control word layout
  localparam int BCC_CW_W = 12;
  localparam int BCC_CW_COUNT_LSB = 0;
  localparam int BCC_CW_PARITY = 8;
  localparam int BCC_CW_MAP = 9;
  localparam int BCC_CW_MAP_LOAD = 10;
  localparam int BCC_CW_INBOUND = 11;

  // ==========================================================================
  // Bus widths and map table layout
  localparam int BCC_ADDR_W = 21;
  localparam int BCC_DATA_W = 16;
  localparam int BCC_COUNT_W = 8;
  localparam int BCC_REQ_W = 8;
  localparam int BCC_PAGE_OFS_W = 15;
  localparam int BCC_MAP_IDX_W = 5;
  localparam int BCC_MAP_ENTRIES = 32;
  localparam int BCC_MAP_PAGE_W = 6;
  localparam int BCC_MAP_PROT_BIT = 15;
  localparam logic BCC_PARITY_ODD = 1'b1;

  // ==========================================================================
  // Timing
  localparam int BCC_CLK_PERIOD_NS = 8;
  localparam int BCC_MIN_BUS_CYCLE_NS = 100;
  localparam int BCC_MIN_BUS_CYCLE_CLKS = (BCC_MIN_BUS_CYCLE_NS + BCC_CLK_PERIOD_NS - 1) / BCC_CLK_PERIOD_NS;
  localparam int BCC_CYC_CNT_W = 5;

  typedef enum logic [1:0] {
    BCC_IDLE = 2'b00,
    BCC_ADDR = 2'b01,
    BCC_DATA = 2'b10
  } bcc_fsm_e;

  typedef struct packed {
    logic link_clock;
    logic [BCC_REQ_W-1:0] request_n;
    logic parity_check_request_n;
    logic translate_address_select_n;
    logic map_load_select_n;
    logic inbound_direction_select_n;
    logic [BCC_COUNT_W-1:0] burst_length_minus_one;
    logic [BCC_ADDR_W-1:0] start_address_lines;
    logic address_parity_bit;
    logic [BCC_DATA_W-1:0] data_lines;
    logic word_parity_bit;
  } bcc_pins_s;

endpackage

// >>> design/bcc_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface bcc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport sync (input raw, output synced);
endinterface
`default_nettype wire

// >>> design/bcc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module bcc_sync
  import bcc_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  bcc_sync_if.sync sif
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } bcc_sync_s;

  bcc_sync_s sync_reg;
  bcc_sync_s sync_next;

  initial begin
    if (W < 1) begin
      $error("bcc_sync needs W of at least 1.");
    end
  end

  // Only the second stage reads the first one.
  always_comb begin
    sync_next = sync_reg;
    sync_next.stage1 = sif.raw;
    sync_next.stage2 = sync_reg.stage1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign sif.synced = sync_reg.stage2;
endmodule
`default_nettype wire

// >>> design/bcc_channel_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module bcc_channel_ctl
  import bcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o,
  output logic irq,
  input wire logic link_clock,
  input wire logic [BCC_REQ_W-1:0] request_n,
  output logic ready_n,
  output logic data_phase_n,
  output logic address_fault_n,
  output logic data_fault_n,
  input wire logic parity_check_request_n,
  input wire logic translate_address_select_n,
  input wire logic map_load_select_n,
  input wire logic inbound_direction_select_n,
  input wire logic [BCC_COUNT_W-1:0] burst_length_minus_one,
  input wire logic [BCC_ADDR_W-1:0] start_address_lines,
  input wire logic address_parity_bit,
  input wire logic [BCC_DATA_W-1:0] data_lines_in,
  output logic [BCC_DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic word_parity_bit_in,
  output logic word_parity_bit_out,
  output logic word_parity_bit_oe,
  output logic mem_req,
  output logic mem_we,
  output logic [BCC_ADDR_W-1:0] mem_addr,
  output logic [BCC_DATA_W-1:0] mem_wdata,
  input wire logic [BCC_DATA_W-1:0] mem_rdata,
  input wire logic mem_ack
);

  localparam int PIN_W = $bits(bcc_pins_s);

  // ==========================================================================
  // State
  typedef struct packed {
    bcc_fsm_e fsm;
    logic link_prev;
    logic [BCC_CYC_CNT_W-1:0] cyc_cnt;
    logic [BCC_CW_W-1:0] cword;
    logic [BCC_ADDR_W-1:0] saddr;
    logic [BCC_ADDR_W-1:0] cur;
    logic [BCC_COUNT_W-1:0] remaining;
    logic ready_n;
    logic data_phase_n;
    logic afault_n;
    logic dfault_n;
    logic [BCC_DATA_W-1:0] dout;
    logic dpar_out;
    logic d_oe;
    logic mem_req;
    logic mem_we;
    logic [BCC_ADDR_W-1:0] mem_addr;
    logic [BCC_DATA_W-1:0] mem_wdata;
    logic [BCC_MAP_ENTRIES-1:0][BCC_DATA_W-1:0] map;
    logic ctrl_en;
    logic [BCC_EVT_W-1:0] status;
    logic [BCC_EVT_W-1:0] mask;
    logic wb_ack;
    logic [31:0] wb_dat;
  } bcc_state_s;

  bcc_state_s st_reg;
  bcc_state_s st_next;
  bcc_pins_s pins;
  bcc_pins_s pins_raw;

  initial begin
    if (BCC_MIN_BUS_CYCLE_CLKS >= (1 << BCC_CYC_CNT_W)) begin
      $error("Bus cycle counter too narrow.");
    end
    if (BCC_MAP_PAGE_W + BCC_PAGE_OFS_W != BCC_ADDR_W) begin
      $error("Map page and offset do not form a physical address.");
    end
  end

  // ==========================================================================
  // Pin synchronisers
  bcc_sync_if #(.W(PIN_W)) pin_sif ();

  always_comb begin
    pins_raw.link_clock = link_clock;
    pins_raw.request_n = request_n;
    pins_raw.parity_check_request_n = parity_check_request_n;
    pins_raw.translate_address_select_n = translate_address_select_n;
    pins_raw.map_load_select_n = map_load_select_n;
    pins_raw.inbound_direction_select_n = inbound_direction_select_n;
    pins_raw.burst_length_minus_one = burst_length_minus_one;
    pins_raw.start_address_lines = start_address_lines;
    pins_raw.address_parity_bit = address_parity_bit;
    pins_raw.data_lines = data_lines_in;
    pins_raw.word_parity_bit = word_parity_bit_in;
  end

  assign pin_sif.raw = pins_raw;
  assign pins = bcc_pins_s'(pin_sif.synced);

  bcc_sync #(.W(PIN_W)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .sif(pin_sif)
  );

  // ==========================================================================
  // Helpers

  // Returns the protect flag above the address to use on memory.
  function automatic logic [BCC_ADDR_W:0] bcc_xlate(
    input logic [BCC_ADDR_W-1:0] a,
    input logic mapped,
    input logic [BCC_MAP_ENTRIES-1:0][BCC_DATA_W-1:0] m
  );
    logic [BCC_DATA_W-1:0] e;
    begin
      e = m[a[BCC_PAGE_OFS_W +: BCC_MAP_IDX_W]];
      if (mapped) begin
        bcc_xlate = {e[BCC_MAP_PROT_BIT], e[BCC_MAP_PAGE_W-1:0], a[BCC_PAGE_OFS_W-1:0]};
      end else begin
        bcc_xlate = {1'b0, a};
      end
    end
  endfunction

  function automatic logic bcc_parity_ok(input logic [BCC_ADDR_W-1:0] v, input logic p);
    begin
      bcc_parity_ok = ((^v) ^ p) == BCC_PARITY_ODD;
    end
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    logic strobe;
    logic [BCC_EVT_W-1:0] evt;
    logic [BCC_EVT_W-1:0] clr;
    logic [BCC_ADDR_W:0] xl;
    logic [BCC_ADDR_W-1:0] nxt_addr;
    logic par_en;
    logic mapped;
    logic map_load;
    logic inbound;
    st_next = st_reg;
    evt = '0;
    clr = '0;
    xl = '0;
    nxt_addr = st_reg.cur + 21'h000001;
    par_en = st_reg.cword[BCC_CW_PARITY];
    mapped = st_reg.cword[BCC_CW_MAP];
    map_load = st_reg.cword[BCC_CW_MAP_LOAD];
    inbound = st_reg.cword[BCC_CW_INBOUND];

    // Active edge of the sync clock is its high to low transition.
    strobe = st_reg.link_prev & ~pins.link_clock;
    st_next.link_prev = pins.link_clock;

    // A bus cycle shorter than the minimum is reported, not refused.
    if (strobe) begin
      st_next.cyc_cnt = '0;
      if (st_reg.cyc_cnt < BCC_CYC_CNT_W'(BCC_MIN_BUS_CYCLE_CLKS - 1)) begin
        evt[BCC_EVT_SHORT_CYCLE] = st_reg.fsm != BCC_IDLE;
      end
    end else if (st_reg.cyc_cnt != {BCC_CYC_CNT_W{1'b1}}) begin
      st_next.cyc_cnt = st_reg.cyc_cnt + 5'h01;
    end

    // Fault lines qualify exactly one bus cycle.
    if (strobe) begin
      st_next.afault_n = 1'b1;
      st_next.dfault_n = 1'b1;
    end

    // Memory side completes a pending access.
    if (st_reg.mem_req && mem_ack) begin
      st_next.mem_req = 1'b0;
      if (!st_reg.mem_we) begin
        st_next.dout = mem_rdata;
        st_next.dpar_out = (^mem_rdata) ^ BCC_PARITY_ODD;
      end
    end

    case (st_reg.fsm)
      BCC_IDLE: begin
        st_next.ready_n = ~st_reg.ctrl_en;
        if (strobe && !st_reg.ready_n && pins.request_n != 8'hFF) begin
          st_next.fsm = BCC_ADDR;
        end
      end
      BCC_ADDR: begin
        if (strobe) begin
          st_next.cword[BCC_CW_COUNT_LSB +: BCC_COUNT_W] = pins.burst_length_minus_one;
          st_next.cword[BCC_CW_PARITY] = ~pins.parity_check_request_n;
          st_next.cword[BCC_CW_MAP] = ~pins.translate_address_select_n;
          st_next.cword[BCC_CW_INBOUND] = ~pins.inbound_direction_select_n;
          st_next.cword[BCC_CW_MAP_LOAD] = ~pins.map_load_select_n & ~pins.inbound_direction_select_n;
          st_next.saddr = pins.start_address_lines;
          st_next.cur = pins.start_address_lines;
          st_next.remaining = pins.burst_length_minus_one;
          st_next.ready_n = 1'b1;
          st_next.data_phase_n = 1'b0;
          st_next.fsm = BCC_DATA;
          if (!pins.parity_check_request_n
              && !bcc_parity_ok(pins.start_address_lines, pins.address_parity_bit)) begin
            st_next.afault_n = 1'b0;
            evt[BCC_EVT_ADDR_FAULT] = 1'b1;
          end
          if (pins.inbound_direction_select_n) begin
            st_next.d_oe = 1'b1;
            xl = bcc_xlate(pins.start_address_lines, ~pins.translate_address_select_n, st_reg.map);
            st_next.mem_req = 1'b1;
            st_next.mem_we = 1'b0;
            st_next.mem_addr = xl[BCC_ADDR_W-1:0];
          end
        end
      end
      BCC_DATA: begin
        if (strobe) begin
          if (inbound) begin
            if (par_en && !bcc_parity_ok({5'h00, pins.data_lines}, pins.word_parity_bit)) begin
              st_next.dfault_n = 1'b0;
              evt[BCC_EVT_DATA_FAULT] = 1'b1;
            end
            if (map_load) begin
              st_next.map[st_reg.cur[BCC_MAP_IDX_W-1:0]] = pins.data_lines;
            end else begin
              xl = bcc_xlate(st_reg.cur, mapped, st_reg.map);
              if (xl[BCC_ADDR_W]) begin
                st_next.afault_n = 1'b0;
                evt[BCC_EVT_ADDR_FAULT] = 1'b1;
              end else begin
                st_next.mem_req = 1'b1;
                st_next.mem_we = 1'b1;
                st_next.mem_addr = xl[BCC_ADDR_W-1:0];
                st_next.mem_wdata = pins.data_lines;
              end
            end
          end else begin
            xl = bcc_xlate(st_reg.cur, mapped, st_reg.map);
            if (xl[BCC_ADDR_W]) begin
              st_next.afault_n = 1'b0;
              evt[BCC_EVT_ADDR_FAULT] = 1'b1;
            end
            if (st_reg.remaining != 8'h00) begin
              xl = bcc_xlate(nxt_addr, mapped, st_reg.map);
              st_next.mem_req = 1'b1;
              st_next.mem_we = 1'b0;
              st_next.mem_addr = xl[BCC_ADDR_W-1:0];
            end
          end
          st_next.cur = nxt_addr;
          if (st_reg.remaining == 8'h00) begin
            st_next.fsm = BCC_IDLE;
            st_next.data_phase_n = 1'b1;
            st_next.d_oe = 1'b0;
            st_next.ready_n = ~st_reg.ctrl_en;
            evt[BCC_EVT_DONE] = 1'b1;
          end else begin
            st_next.remaining = st_reg.remaining - 8'h01;
          end
        end
      end
      default: begin
        st_next.fsm = BCC_IDLE;
      end
    endcase

    // Register slave: one wait state, unmapped reads return zero.
    st_next.wb_ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !st_reg.wb_ack) begin
      st_next.wb_ack = 1'b1;
      st_next.wb_dat = '0;
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          BCC_OFS_CTRL: st_next.ctrl_en = wb_dat_i[BCC_CTRL_ENABLE];
          BCC_OFS_STATUS: clr = wb_dat_i[BCC_EVT_W-1:0];
          BCC_OFS_MASK: st_next.mask = wb_dat_i[BCC_EVT_W-1:0];
          default: begin
          end
        endcase
      end else if (!wb_we_i) begin
        case (wb_adr_i)
          BCC_OFS_CTRL: st_next.wb_dat = {31'h00000000, st_reg.ctrl_en};
          BCC_OFS_STATUS: st_next.wb_dat = {28'h0000000, st_reg.status};
          BCC_OFS_MASK: st_next.wb_dat = {28'h0000000, st_reg.mask};
          BCC_OFS_CWORD: st_next.wb_dat = {18'h00000, st_reg.fsm, st_reg.cword};
          BCC_OFS_SADDR: st_next.wb_dat = {11'h000, st_reg.saddr};
          default: st_next.wb_dat = '0;
        endcase
      end
    end

    // A hardware event wins over a clear in the same cycle.
    st_next.status = (st_reg.status & ~clr) | evt;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.fsm <= BCC_IDLE;
      st_reg.ready_n <= 1'b1;
      st_reg.data_phase_n <= 1'b1;
      st_reg.afault_n <= 1'b1;
      st_reg.dfault_n <= 1'b1;
      st_reg.ctrl_en <= BCC_CTRL_ENABLE_RST;
      st_reg.status <= BCC_STATUS_RST;
      st_reg.mask <= BCC_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_ack_o = st_reg.wb_ack;
  assign wb_dat_o = st_reg.wb_dat;
  assign irq = |(st_reg.status & st_reg.mask);
  assign ready_n = st_reg.ready_n;
  assign data_phase_n = st_reg.data_phase_n;
  assign address_fault_n = st_reg.afault_n;
  assign data_fault_n = st_reg.dfault_n;
  assign data_lines_out = st_reg.dout;
  assign data_lines_oe = st_reg.d_oe;
  assign word_parity_bit_out = st_reg.dpar_out;
  assign word_parity_bit_oe = st_reg.d_oe;
  assign mem_req = st_reg.mem_req;
  assign mem_we = st_reg.mem_we;
  assign mem_addr = st_reg.mem_addr;
  assign mem_wdata = st_reg.mem_wdata;

endmodule
`default_nettype wire

// >>> sim/bcc_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Port-level checks of the channel controller.
module bcc_chk
  import bcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic ready_n,
  input wire logic data_phase_n,
  input wire logic address_fault_n,
  input wire logic data_fault_n,
  input wire logic data_lines_oe,
  input wire logic word_parity_bit_oe,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [BCC_ADDR_W-1:0] mem_addr,
  input wire logic mem_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence af_hold_s;
    !address_fault_n [*8];
  endsequence
  sequence df_hold_s;
    !data_fault_n [*8];
  endsequence
  chk_wb_answer: assert property (wb_req_s |=> wb_ack_o)
    else $error("Bus request not answered.");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Bus ack longer than one cycle.");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("Bus ack without request.");
  chk_addr_fault_hold: assert property ($fell(address_fault_n) |-> af_hold_s)
    else $error("Address fault too short.");
  chk_data_fault_hold: assert property ($fell(data_fault_n) |-> df_hold_s)
    else $error("Data fault too short.");
  chk_addr_fault_phase: assert property ($fell(address_fault_n) |-> !data_phase_n || $rose(data_phase_n))
    else $error("Address fault outside a burst.");
  chk_data_fault_dir: assert property ($fell(data_fault_n) |-> !data_lines_oe)
    else $error("Data fault on outbound word.");
  chk_drive_phase: assert property (data_lines_oe |-> word_parity_bit_oe && !data_phase_n)
    else $error("Data driven outside data phase.");
  chk_ready_busy: assert property (!data_phase_n |-> ready_n)
    else $error("Ready during data phase.");
  chk_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("Memory request not held.");
  chk_write_dir: assert property (mem_req && mem_we |-> !data_lines_oe)
    else $error("Memory write while driving out.");
endmodule
`default_nettype wire

// >>> sim/bcc_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Device controller: requests, presents the control word, moves the words.
module bcc_dev_model (
  input wire logic clk,
  input wire logic link_clock,
  input wire logic ready_n,
  input wire logic address_fault_n,
  input wire logic data_fault_n,
  input wire logic [15:0] bus_d,
  input wire logic bus_p,
  input wire logic bus_oe,
  output logic [7:0] request_n,
  output logic [11:0] ctl,
  output logic [20:0] addr,
  output logic apar,
  output logic [15:0] dev_d,
  output logic dev_p
);
  int words, afaults, dfaults, pbad;
  logic [15:0] rsum;
  initial begin
    request_n = 8'hFF;
    ctl = 12'hF00;
    addr = 21'h0;
    apar = 1'h0;
    dev_d = 16'h0;
    dev_p = 1'h0;
  end
  // Pins change half a bus cycle from the strobe, so they are stable around it.
  task automatic launch;
    @(posedge link_clock);
    @(posedge clk);
  endtask
  task automatic sample;
    afaults += int'(address_fault_n === 1'h0);
    dfaults += int'(data_fault_n === 1'h0);
    if (bus_oe === 1'h1) begin
      words++;
      rsum ^= bus_d;
      pbad += int'(^{bus_d, bus_p} !== 1'h1);
    end
  endtask
  task automatic burst(input logic [13:0] cfg, input logic [20:0] a, input logic [15:0] d0);
    int n;
    logic [15:0] w;
    {words, afaults, dfaults, pbad, n} = '0;
    rsum = 16'h0;
    launch();
    request_n <= 8'hFE;
    do @(negedge link_clock); while (ready_n !== 1'h0 && n++ < 20);
    launch();
    request_n <= 8'hFF;
    ctl <= cfg[11:0];
    addr <= a;
    apar <= (~^a) ^ cfg[12];
    @(negedge link_clock);
    for (int i = 0; i <= int'(cfg[7:0]); i++) begin
      w = d0 + 16'(i);
      launch();
      ctl <= ~cfg[11:0] | 12'h400;
      addr <= ~a;
      dev_d <= cfg[11] ? ~bus_d : w;
      dev_p <= cfg[11] ? ~bus_p : (~^w) ^ (cfg[13] && i == 0);
      @(negedge link_clock);
      sample();
    end
    launch();
    dev_d <= ~dev_d;
    dev_p <= ~dev_p;
    @(negedge link_clock);
    sample();
  endtask
endmodule
`default_nettype wire

// >>> sim/burst_channel_control_word_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// Self-checking bench of the burst channel controller.
module burst_channel_control_word_bench
  import bcc_pkg::*;
;
  typedef struct {
    logic [13:0] cfg;
    logic [20:0] a;
    logic [15:0] d0;
    int wr;
    int rd;
    int af;
    int df;
  } bcc_row_s;
  logic clk = 1'h0, rst = 1'h1, wb_we_i = 1'h0, wb_stb_i = 1'h0, wb_cyc_i = 1'h0, link_clock = 1'h1;
  logic wb_ack_o, irq, ready_n, data_phase_n, address_fault_n, data_fault_n, dev_p, address_parity_bit;
  logic parity_check_request_n, translate_address_select_n, map_load_select_n, inbound_direction_select_n;
  logic [7:0] wb_adr_i = 8'h0, request_n, burst_length_minus_one;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'h0;
  logic [11:0] ctl;
  logic [20:0] start_address_lines, mem_addr, wr_a;
  logic [15:0] data_lines_in, data_lines_out, dev_d, mem_wdata, wr_d, mem_rdata = 16'h0;
  logic data_lines_oe, word_parity_bit_in, word_parity_bit_out, word_parity_bit_oe;
  logic mem_req, mem_we, mem_ack = 1'h0;
  int fail_count = 0, checks_done = 0, wr_n = 0, w0;
  bcc_row_s rows [6] = '{
    '{14'h0700, 21'h012340, 16'h1111, 1, 0, 0, 0},
    '{14'h3703, 21'h000100, 16'h2000, 4, 0, 0, 0},
    '{14'h0602, 21'h1FFFF0, 16'hFFFE, 3, 0, 0, 0},
    '{14'h2E02, 21'h00FFFF, 16'h0000, 0, 3, 0, 0},
    '{14'h0B01, 21'h000040, 16'h0000, 0, 2, 0, 0},
    '{14'h07FF, 21'h010000, 16'h0100, 256, 0, 0, 0}
  };
  assign {inbound_direction_select_n, map_load_select_n, translate_address_select_n} = ctl[11:9];
  assign {parity_check_request_n, burst_length_minus_one} = ctl[8:0];
  assign data_lines_in = data_lines_oe ? data_lines_out : dev_d;
  assign word_parity_bit_in = word_parity_bit_oe ? word_parity_bit_out : dev_p;
  always #4 clk = ~clk;
  // The sync clock runs free with an 80 ns period, moved on rising edges of clk.
  initial begin
    forever begin
      repeat (5) @(posedge clk);
      link_clock <= ~link_clock;
    end
  end
  // Memory answers one cycle after each request and logs every write.
  always @(posedge clk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= mem_addr[15:0] ^ 16'h5A5A;
    if (mem_req && mem_ack && mem_we) begin
      wr_n <= wr_n + 1;
      wr_a <= mem_addr;
      wr_d <= mem_wdata;
    end
  end
  bcc_channel_ctl dut (
    .clk, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .irq,
    .link_clock, .request_n, .ready_n, .data_phase_n, .address_fault_n, .data_fault_n,
    .parity_check_request_n, .translate_address_select_n, .map_load_select_n, .inbound_direction_select_n,
    .burst_length_minus_one, .start_address_lines, .address_parity_bit, .data_lines_in, .data_lines_out,
    .data_lines_oe, .word_parity_bit_in, .word_parity_bit_out, .word_parity_bit_oe,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack
  );
  bcc_dev_model dev (.clk, .link_clock, .ready_n, .address_fault_n, .data_fault_n, .bus_d(data_lines_in),
    .bus_p(word_parity_bit_in), .bus_oe(data_lines_oe), .request_n, .ctl, .addr(start_address_lines),
    .apar(address_parity_bit), .dev_d, .dev_p);
  task automatic wrap_up;
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk); while (wb_ack_o !== 1'h1 && n++ < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 20) fail_count++;
  endtask
  function automatic logic [15:0] xsum(input logic [20:0] a, input int n);
    logic [15:0] s;
    s = 16'h0;
    for (int i = 0; i < n; i++) s ^= (a[15:0] + 16'(i)) ^ 16'h5A5A;
    return s;
  endfunction
  task automatic run(input bcc_row_s r);
    w0 = wr_n;
    dev.burst(r.cfg, r.a, r.d0);
    if (r.wr >= 0) chk(wr_n - w0, r.wr);
    chk(dev.words, r.rd);
    if (r.rd > 0) chk(dev.rsum, xsum(r.a, r.rd));
    chk(dev.pbad, 0);
    chk(dev.afaults, r.af);
    chk(dev.dfaults, r.df);
    if (r.wr > 0 && r.cfg[9]) chk(wr_a, r.a + r.wr - 1);
    if (r.wr > 0) chk(wr_d, 16'(r.d0 + r.wr - 1));
    wb(BCC_OFS_CWORD, 1'h0, 32'h0);
    chk(q[11:0], {~r.cfg[11], ~r.cfg[11] & ~r.cfg[10], ~r.cfg[9:8], r.cfg[7:0]});
    wb(BCC_OFS_SADDR, 1'h0, 32'h0);
    chk(q[20:0], r.a);
    chk(irq, 1'h1);
    wb(BCC_OFS_STATUS, 1'h1, 32'hF);
    chk(irq, 1'h0);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    wb(BCC_OFS_CTRL, 1'h0, 32'h0);
    chk(q, 32'h1);
    wb(BCC_OFS_STATUS, 1'h0, 32'h0);
    chk(q[2:0], 3'h0);
    wb(BCC_OFS_MASK, 1'h0, 32'h0);
    chk(q, 32'h0);
    wb(8'h40, 1'h1, 32'hFF);
    wb(8'h40, 1'h0, 32'h0);
    chk(q, 32'h0);
    wb(BCC_OFS_CTRL, 1'h1, 32'h0);
    repeat (4) @(negedge clk);
    chk(ready_n, 1'h1);
    wb(BCC_OFS_CTRL, 1'h1, 32'h1);
    repeat (4) @(negedge clk);
    chk(ready_n, 1'h0);
    wb(BCC_OFS_MASK, 1'h1, 32'h4);
    foreach (rows[i]) run(rows[i]);
    run(bcc_row_s'{14'h1600, 21'h000200, 16'h3000, -1, 0, 1, 0});
    run(bcc_row_s'{14'h2601, 21'h000300, 16'h4000, -1, 0, 0, 1});
    run(bcc_row_s'{14'h0301, 21'h000000, 16'h7FFF, 0, 0, 0, 0});
    run(bcc_row_s'{14'h0500, 21'h000123, 16'h5555, 1, 0, 0, 0});
    chk(wr_a, 21'h1F8123);
    run(bcc_row_s'{14'h0500, 21'h008123, 16'h6666, 0, 0, 1, 0});
    wb(BCC_OFS_MASK, 1'h1, 32'h0);
    dev.burst(14'h1600, 21'h000400, 16'h0);
    chk(irq, 1'h0);
    wb(BCC_OFS_STATUS, 1'h0, 32'h0);
    chk(q[3:0], 4'hD);
    wb(BCC_OFS_CTRL, 1'h1, 32'h0);
    rst <= 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    wb(BCC_OFS_STATUS, 1'h0, 32'h0);
    chk(q, 32'h0);
    wb(BCC_OFS_CTRL, 1'h0, 32'h0);
    chk(q, 32'h1);
    chk(ready_n, 1'h0);
    wrap_up();
  end
  initial begin
    #300000;
    fail_count++;
    wrap_up();
  end
endmodule
bind bcc_channel_ctl bcc_chk u_chk (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ready_n, .data_phase_n,
  .address_fault_n, .data_fault_n, .data_lines_oe, .word_parity_bit_oe, .mem_req, .mem_we, .mem_addr, .mem_ack);
`default_nettype wire
